// [inc/lti_pkg.sv]
`default_nettype none
package lti_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [7:0] ADDR_INT_CTRL = 8'h02;
    localparam logic [7:0] ADDR_LOW_LIM_LO = 8'h03;
    localparam logic [7:0] ADDR_LOW_LIM_HI = 8'h04;
    localparam logic [7:0] ADDR_HIGH_LIM_LO = 8'h05;
    localparam logic [7:0] ADDR_HIGH_LIM_HI = 8'h06;
    localparam logic [7:0] ADDR_EVT_STATUS = 8'h20;
    localparam logic [7:0] ADDR_EVT_MASK = 8'h21;
    localparam logic [7:0] ADDR_LINE_STATE = 8'h22;
    // limit bytes sit on consecutive offsets starting here
    localparam logic [7:0] ADDR_LIMIT_BASE = 8'h03;
    localparam int LIMIT_BYTES = 4;
    // interrupt control field layout
    localparam int PERSIST_LSB = 0;
    localparam int PERSIST_W = 4;
    localparam int STYLE_LSB = 4;
    localparam int STYLE_W = 2;
    localparam logic [7:0] INT_CTRL_RESET = 8'h00;
    localparam logic [7:0] INT_CTRL_MASK = 8'h3F;
    // event status bits
    localparam int EVT_W = 2;
    localparam int EVT_RAISE = 0;
    localparam int EVT_CONV = 1;
    localparam logic [1:0] EVT_RESET = 2'h0;
    // line-state read layout
    localparam int LS_PEND = 0;
    localparam int LS_CNT_LSB = 4;
    // special function command: clear field value that clears
    localparam int SF_FIELD_W = 5;
    localparam logic [4:0] SF_INT_CLEAR = 5'h00;
    localparam int RESULT_W = 16;
    localparam logic [3:0] PERSIST_EVERY = 4'h0;
    localparam logic [3:0] PERSIST_MAX = 4'hF;

    // interrupt styles
    typedef enum logic [1:0] {
        LTI_STYLE_OFF = 2'h0,
        LTI_STYLE_LEVEL = 2'h1,
        LTI_STYLE_ALERT = 2'h2,
        LTI_STYLE_RSVD = 2'h3
    } lti_style_type;

    // interrupt line state, gray along idle -> pending -> alert wait
    typedef enum logic [1:0] {
        LTI_LINE_IDLE = 2'h0,
        LTI_LINE_PEND = 2'h1,
        LTI_LINE_ALERT = 2'h3
    } lti_line_type;

    // one finished conversion
    typedef struct packed {
        logic done;
        logic [15:0] ch0;
        logic [15:0] ch1;
    } lti_conv_type;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lti_bus_type;

    // special function command from the serial engine
    typedef struct packed {
        logic valid;
        logic [4:0] field;
    } lti_sf_type;
endpackage
`default_nettype wire

// [design/lti_window_filter.sv]
`default_nettype none
// window compare plus persistence count for channel 0 results
module lti_window_filter (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic conv_done,
    input wire logic [15:0] ch0,
    input wire logic [15:0] low_lim,
    input wire logic [15:0] high_lim,
    input wire logic [3:0] persist,
    input wire logic cnt_clear,
    output logic raise,
    output logic [3:0] run_cnt
);
    logic [3:0] cnt_r; // consecutive out-of-window results
    logic [3:0] cnt_nxt;
    logic outside; // result strictly outside the window
    logic [3:0] cnt_base; // count after any clear in this cycle
    logic [3:0] cnt_inc; // saturating increment
    logic every; // end-of-conversion mode

    // strict compares, equality to a limit stays inside
    assign outside = (ch0 < low_lim) || (ch0 > high_lim);
    assign every = (persist == lti_pkg::PERSIST_EVERY);
    // a clear restarts the run; this cycle's result then counts as its first
    assign cnt_base = cnt_clear ? 4'h0 : cnt_r;
    assign cnt_inc = (cnt_base == lti_pkg::PERSIST_MAX) ? cnt_base : cnt_base + 4'h1;

    // count only on a finished conversion; in-window result restarts
    assign cnt_nxt = !conv_done ? cnt_base :
        every ? 4'h0 :
        outside ? cnt_inc : 4'h0;

    // raise: every conversion in mode zero, thresholds ignored
    // a clear in the same cycle restarts the count, so with persistence above one it can hide the event
    assign raise = conv_done &&
        (every || (outside && (cnt_inc >= persist)));
    assign run_cnt = cnt_r;

    // persistence counter
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// [design/lti_top.sv]
// Our own choices: the placing of the registers and strobed register access.
`default_nettype none
// How it works
// - control register zero means no pin interrupts; an unmasked conversion event still drives irq
// - style field selects off, level or alert
// - two 16-bit limits define the window
// - only channel 0 result is compared
// - persistence one raises on first outlier
// - persistence N needs N consecutive outliers
// - line held low until the interrupt clears
// - level style cleared by special function zero
// - alert style cleared by alert response
// - persistence zero raises every conversion
// - low limit bytes at offsets three, four
// - high limit bytes at offsets five, six
module lti_top (
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire lti_pkg::lti_bus_type bus,
    output logic [7:0] rdata,
    // conversion results from the converter
    input wire lti_pkg::lti_conv_type conv,
    // commands decoded by the serial engine
    input wire lti_pkg::lti_sf_type sf_cmd,
    input wire logic alert_resp_req,
    output logic alert_resp_ack,
    // serial clock pin, used to time the alert release
    input wire logic scl_pin,
    // open-drain interrupt pin, active low
    output logic int_n_o,
    output logic int_n_oe,
    // internal event interrupt
    output logic irq
);
    // register storage
    logic [7:0] int_ctrl_r; // style and persistence
    logic [7:0] limit_r [lti_pkg::LIMIT_BYTES]; // low lo, low hi, high lo, high hi
    logic [1:0] evt_status_r; // sticky events
    logic [1:0] evt_mask_r; // event enables
    logic [7:0] rdata_r; // registered read data
    logic [7:0] rdata_nxt;

    // line control
    lti_pkg::lti_line_type line_r;
    lti_pkg::lti_line_type line_nxt;
    logic int_drv_r; // pin drive, registered
    logic alert_ack_r; // answer pulse to the engine
    logic alert_ack_nxt;

    // serial clock synchroniser
    logic scl_meta_r; // first stage, read only by the second
    logic scl_sync_r;
    logic scl_prev_r;
    logic scl_fall;

    // decoded controls
    lti_pkg::lti_style_type style;
    logic [3:0] persist;
    logic int_enabled;
    logic [15:0] low_lim;
    logic [15:0] high_lim;
    logic raise;
    logic [3:0] run_cnt;
    logic level_clear;
    logic alert_clear;
    logic any_clear;
    logic ctrl_write;
    logic status_write;
    logic mask_write;
    logic [1:0] evt_set;
    logic [1:0] status_nxt;

    // address compare used by every write and read decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ---------------- decode ----------------
    assign style = lti_pkg::lti_style_type'(
        int_ctrl_r[lti_pkg::STYLE_LSB +: lti_pkg::STYLE_W]);
    assign persist = int_ctrl_r[lti_pkg::PERSIST_LSB +: lti_pkg::PERSIST_W];
    // reserved style code behaves as disabled; all-zero control is disabled
    assign int_enabled = (int_ctrl_r != lti_pkg::INT_CTRL_RESET) &&
        ((style == lti_pkg::LTI_STYLE_LEVEL) ||
        (style == lti_pkg::LTI_STYLE_ALERT));
    // little-endian byte pairs
    assign low_lim = {limit_r[1], limit_r[0]};
    assign high_lim = {limit_r[3], limit_r[2]};

    assign ctrl_write = bus.wr && hit(bus.addr, lti_pkg::ADDR_INT_CTRL);
    assign status_write = bus.wr && hit(bus.addr, lti_pkg::ADDR_EVT_STATUS);
    assign mask_write = bus.wr && hit(bus.addr, lti_pkg::ADDR_EVT_MASK);

    // clear sources: level clear only in level style while pending, alert clear only in the alert wait state
    assign level_clear = sf_cmd.valid && (sf_cmd.field == lti_pkg::SF_INT_CLEAR) &&
        (style == lti_pkg::LTI_STYLE_LEVEL) && (line_r == lti_pkg::LTI_LINE_PEND);
    assign alert_clear = (line_r == lti_pkg::LTI_LINE_ALERT) && scl_fall;
    assign any_clear = level_clear || alert_clear || !int_enabled;

    // ---------------- threshold filter ----------------
    // channel 1 is deliberately not wired in
    lti_window_filter u_filter (
        .core_clk(core_clk),
        .rst(rst),
        .conv_done(conv.done && int_enabled),
        .ch0(conv.ch0),
        .low_lim(low_lim),
        .high_lim(high_lim),
        .persist(persist),
        .cnt_clear(any_clear),
        .raise(raise),
        .run_cnt(run_cnt)
    );

    // ---------------- serial clock edges ----------------
    assign scl_fall = scl_prev_r && !scl_sync_r;

    // two stages before anything looks at the pin
    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_meta_r <= 1'b1;
            scl_sync_r <= 1'b1;
            scl_prev_r <= 1'b1;
        end else begin
            scl_meta_r <= scl_pin;
            scl_sync_r <= scl_meta_r;
            scl_prev_r <= scl_sync_r;
        end
    end

    // ---------------- interrupt line ----------------
    // next state; a raise landing with a clear keeps the line pending
    always_comb begin
        line_nxt = line_r;
        alert_ack_nxt = 1'b0;
        case (line_r)
            lti_pkg::LTI_LINE_IDLE: begin
                if (raise && int_enabled) begin
                    line_nxt = lti_pkg::LTI_LINE_PEND;
                end
            end
            lti_pkg::LTI_LINE_PEND: begin
                if (!int_enabled) begin
                    line_nxt = lti_pkg::LTI_LINE_IDLE;
                end else if (level_clear && !raise) begin
                    line_nxt = lti_pkg::LTI_LINE_IDLE;
                end else if (alert_resp_req && style == lti_pkg::LTI_STYLE_ALERT) begin
                    // answer now, let go of the line once the ack bit has gone out
                    line_nxt = lti_pkg::LTI_LINE_ALERT;
                    alert_ack_nxt = 1'b1;
                end
            end
            lti_pkg::LTI_LINE_ALERT: begin
                if (!int_enabled) begin
                    line_nxt = lti_pkg::LTI_LINE_IDLE;
                end else if (raise) begin
                    // fresh event while answering: line stays low, pending again
                    line_nxt = lti_pkg::LTI_LINE_PEND;
                end else if (scl_fall) begin
                    line_nxt = lti_pkg::LTI_LINE_IDLE;
                end
            end
            default: begin
                line_nxt = lti_pkg::LTI_LINE_IDLE;
            end
        endcase
    end

    // line state and pin drive, low while pending or answering
    always_ff @(posedge core_clk) begin
        if (rst) begin
            line_r <= lti_pkg::LTI_LINE_IDLE;
            int_drv_r <= 1'b0;
            alert_ack_r <= 1'b0;
        end else begin
            line_r <= line_nxt;
            int_drv_r <= (line_nxt != lti_pkg::LTI_LINE_IDLE);
            alert_ack_r <= alert_ack_nxt;
        end
    end

    // open drain: value is always low, enable decides
    assign int_n_o = 1'b0;
    assign int_n_oe = int_drv_r;
    assign alert_resp_ack = alert_ack_r;

    // ---------------- registers ----------------
    // control register, reserved bits forced to zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            int_ctrl_r <= lti_pkg::INT_CTRL_RESET;
        end else if (ctrl_write) begin
            int_ctrl_r <= bus.wdata & lti_pkg::INT_CTRL_MASK;
        end
    end

    // one write decoder per limit byte
    genvar gi;
    generate
        for (gi = 0; gi < lti_pkg::LIMIT_BYTES; gi++) begin : g_limit
            logic byte_write;
            assign byte_write = bus.wr &&
                hit(bus.addr, lti_pkg::ADDR_LIMIT_BASE + 8'(gi));
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    limit_r[gi] <= 8'h00;
                end else if (byte_write) begin
                    limit_r[gi] <= bus.wdata;
                end
            end
        end
    endgenerate

    // sticky events: set wins over a write-one clear in the same cycle
    assign evt_set[lti_pkg::EVT_RAISE] = raise && int_enabled;
    assign evt_set[lti_pkg::EVT_CONV] = conv.done;
    assign status_nxt = (evt_status_r &
        ~(status_write ? bus.wdata[1:0] : 2'h0)) | evt_set;

    // status and mask
    always_ff @(posedge core_clk) begin
        if (rst) begin
            evt_status_r <= lti_pkg::EVT_RESET;
            evt_mask_r <= lti_pkg::EVT_RESET;
        end else begin
            evt_status_r <= status_nxt;
            if (mask_write) begin
                evt_mask_r <= bus.wdata[1:0];
            end
        end
    end

    // level output while any unmasked event stays set
    assign irq = |(evt_status_r & evt_mask_r);

    // ---------------- read path ----------------
    // read mux; unmapped offsets read as zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (hit(bus.addr, lti_pkg::ADDR_INT_CTRL)) begin
            rdata_nxt = int_ctrl_r;
        end else if (hit(bus.addr, lti_pkg::ADDR_LOW_LIM_LO)) begin
            rdata_nxt = limit_r[0];
        end else if (hit(bus.addr, lti_pkg::ADDR_LOW_LIM_HI)) begin
            rdata_nxt = limit_r[1];
        end else if (hit(bus.addr, lti_pkg::ADDR_HIGH_LIM_LO)) begin
            rdata_nxt = limit_r[2];
        end else if (hit(bus.addr, lti_pkg::ADDR_HIGH_LIM_HI)) begin
            rdata_nxt = limit_r[3];
        end else if (hit(bus.addr, lti_pkg::ADDR_EVT_STATUS)) begin
            rdata_nxt = {6'h00, evt_status_r};
        end else if (hit(bus.addr, lti_pkg::ADDR_EVT_MASK)) begin
            rdata_nxt = {6'h00, evt_mask_r};
        end else if (hit(bus.addr, lti_pkg::ADDR_LINE_STATE)) begin
            // pending flag and live persistence count
            rdata_nxt[lti_pkg::LS_PEND] = (line_r != lti_pkg::LTI_LINE_IDLE);
            rdata_nxt[lti_pkg::LS_CNT_LSB +: 4] = run_cnt;
        end
    end

    // read data stands for exactly the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (bus.rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign rdata = rdata_r;
endmodule
`default_nettype wire

// [verif/lti_asserts.sv]
`default_nettype none
// interrupt line timing, judged against shadows of control and limits
module lti_asserts (
    input wire logic core_clk,
    input wire logic rst,
    input wire lti_pkg::lti_bus_type bus,
    input wire lti_pkg::lti_conv_type conv,
    input wire lti_pkg::lti_sf_type sf_cmd,
    input wire logic alert_resp_req,
    input wire logic alert_resp_ack,
    input wire logic scl_pin,
    input wire logic int_n_oe
);
    logic [7:0] ctrl_r; // control shadow
    logic [31:0] lim_r; // limit shadow, low limit in 15:0
    logic ack_r; // answered, release still owed
    wire logic [1:0] idx = bus.addr[1:0] + 2'h1; // offsets 03..06 to bytes 0..3
    wire logic lim_wr = bus.wr && bus.addr >= 8'h03 && bus.addr <= 8'h06;
    wire logic en = ctrl_r[5:4] == 2'h1 || ctrl_r[5:4] == 2'h2;
    wire logic out_w = conv.ch0 < lim_r[15:0] || conv.ch0 > lim_r[31:16];
    wire logic lvl_clr = sf_cmd.valid && sf_cmd.field == 5'h00 && ctrl_r[5:4] == 2'h1;
    // shadows take writes at the same edge as the block
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r <= 8'h00;
            lim_r <= 32'h0;
            ack_r <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == 8'h02) ctrl_r <= bus.wdata;
            if (lim_wr) lim_r[{idx, 3'h0} +: 8] <= bus.wdata;
            ack_r <= alert_resp_ack || (ack_r && int_n_oe);
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence s_ack; alert_resp_ack; endsequence
    sequence s_scl_fall; $fell(scl_pin); endsequence
    property p_off; !en && !$past(en) |-> !int_n_oe; endproperty
    property p_every; conv.done && en && ctrl_r[3:0] == 4'h0 && !bus.wr && !alert_resp_req
        |=> int_n_oe; endproperty
    property p_first; conv.done && en && ctrl_r[3:0] == 4'h1 && out_w && !bus.wr
        && !alert_resp_req |=> int_n_oe; endproperty
    property p_inwin; !int_n_oe && conv.done && ctrl_r[3:0] != 4'h0 && !out_w && !bus.wr
        |=> !int_n_oe; endproperty
    property p_hold; int_n_oe && !lvl_clr && !bus.wr && !ack_r |=> int_n_oe; endproperty
    property p_lvl; int_n_oe && lvl_clr && !conv.done && !bus.wr |=> !int_n_oe; endproperty
    property p_ack; alert_resp_req && ctrl_r[5:4] == 2'h2 && int_n_oe |=> s_ack; endproperty
    property p_arel; s_ack ##[1:100] s_scl_fall |-> ##[1:6] !int_n_oe; endproperty
    a_off: assert property (p_off) else $error("line driven while off");
    a_every: assert property (p_every) else $error("no raise at conversion");
    a_first: assert property (p_first) else $error("no raise on first outlier");
    a_inwin: assert property (p_inwin) else $error("raise inside window");
    a_hold: assert property (p_hold) else $error("line dropped uncleared");
    a_lvl: assert property (p_lvl) else $error("level clear ignored");
    a_ack: assert property (p_ack) else $error("alert response unanswered");
    a_arel: assert property (p_arel) else $error("alert line not released");
endmodule
`default_nettype wire

// [verif/lti_host_model.sv]
`default_nettype none
// host side: serial clock in frames only, clear commands, pulled-up line
module lti_host_model (
    input wire logic core_clk,
    input wire logic int_n_o,
    input wire logic int_n_oe,
    input wire logic alert_resp_ack,
    output var logic scl_pin,
    output var lti_pkg::lti_sf_type sf_cmd,
    output var logic alert_resp_req,
    output logic int_line
);
    timeunit 1ns;
    timeprecision 100ps;
    // pull-up wins whenever the block lets go
    assign int_line = int_n_oe ? int_n_o : 1'b1;
    initial begin
        scl_pin = 1'b1;
        sf_cmd = '0;
        alert_resp_req = 1'b0;
    end
    // nine clocks of 125 ns, idle high between frames
    task automatic frame();
        repeat (9) begin
            #62.5 scl_pin = 1'b0;
            #62.5 scl_pin = 1'b1;
        end
    endtask
    // special function command with a chosen field
    task automatic level_clear(input logic [4:0] f);
        @(posedge core_clk);
        sf_cmd <= {1'b1, f};
        @(posedge core_clk);
        sf_cmd.valid <= 1'b0;
    endtask
    // alert response, then a frame after gap cycles (slow host)
    task automatic alert_clear(output logic got, input int gap);
        @(posedge core_clk);
        alert_resp_req <= 1'b1;
        @(posedge core_clk);
        alert_resp_req <= 1'b0;
        #1 got = alert_resp_ack;
        repeat (gap) @(posedge core_clk);
        frame();
    endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    lti_pkg::lti_bus_type bus = '0;
    lti_pkg::lti_conv_type conv = '0;
    lti_pkg::lti_sf_type sf_cmd;
    logic alert_resp_req, alert_resp_ack, scl_pin, int_n_o, int_n_oe, irq, int_line, got;
    logic [7:0] rdata;
    logic [7:0] q[$]; // expected read data, oldest first
    logic rd_d = 1'b0; // a read was issued last cycle
    logic [15:0] lo, hi;
    logic [7:0] ra[9] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h20, 8'h21, 8'h22, 8'h7F};
    logic [3:0] pn[2] = '{4'h2, 4'hF}; // persistence two and the longest, fifteen
    int err_total = 0;
    int n_checks = 0;
    int seed = 32'h4FEE;
    always #5 core_clk = ~core_clk;
    lti_top DUT (.core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata), .conv(conv),
        .sf_cmd(sf_cmd), .alert_resp_req(alert_resp_req), .alert_resp_ack(alert_resp_ack),
        .scl_pin(scl_pin), .int_n_o(int_n_o), .int_n_oe(int_n_oe), .irq(irq));
    lti_host_model host (.core_clk(core_clk), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
        .alert_resp_ack(alert_resp_ack), .scl_pin(scl_pin), .sf_cmd(sf_cmd),
        .alert_resp_req(alert_resp_req), .int_line(int_line));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus <= {a, d, 2'b10};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask
    // read, noting the expected data for the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        bus <= {a, 8'h00, 2'b01};
        q.push_back(e);
        @(posedge core_clk);
        bus.rd <= 1'b0;
    endtask
    // one conversion, random channel 1, then the pin level
    task automatic conv1(input logic [15:0] c0, input logic e);
        @(posedge core_clk);
        conv <= {1'b1, c0, 16'($random(seed))};
        @(posedge core_clk);
        conv.done <= 1'b0;
        #1 chk(int_line, e);
    endtask
    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // read data stands only in the cycle after the strobe
    always @(negedge core_clk) begin
        if (rd_d) chk(rdata, q.pop_front());
        rd_d = bus.rd;
    end
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #300us;
        err_total++;
        results();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        foreach (ra[i]) rd(ra[i], 8'h00);
        tdone("reset");
        lo = 16'h1000 + 16'($random(seed) & 32'hFFF);
        hi = lo + 16'h8000;
        for (int i = 0; i < 4; i++) wr(8'h03 + 8'(i), 8'({hi, lo} >> (8 * i)));
        for (int i = 0; i < 4; i++) rd(8'h03 + 8'(i), 8'({hi, lo} >> (8 * i)));
        tdone("limits");
        conv1(16'h0000, 1'b1);
        rd(8'h20, 8'h02);
        wr(8'h20, 8'h03);
        wr(8'h02, 8'h31);
        conv1(16'h0000, 1'b1);
        tdone("off");
        wr(8'h02, 8'h11);
        wr(8'h21, 8'h01);
        conv1(lo, 1'b1);
        conv1(hi, 1'b1);
        conv1(lo - 16'h1, 1'b0);
        chk(irq, 1'b1);
        host.level_clear(5'h01);
        #1 chk(int_line, 1'b0);
        host.level_clear(5'h00);
        #1 chk(int_line, 1'b1);
        wr(8'h20, 8'h01);
        #1 chk(irq, 1'b0);
        conv1(hi + 16'h1, 1'b0);
        host.level_clear(5'h00);
        tdone("window");
        foreach (pn[i]) begin
            wr(8'h02, 8'h00);
            wr(8'h02, {4'h1, pn[i]});
            repeat (pn[i] - 4'h1) conv1(lo - 16'h1, 1'b1);
            rd(8'h22, {pn[i] - 4'h1, 4'h0});
            conv1(lo, 1'b1);
            repeat (pn[i] - 4'h1) conv1(hi + 16'h1, 1'b1);
            conv1(hi + 16'h1, 1'b0);
            host.level_clear(5'h00);
            conv1(hi + 16'h1, 1'b1);
        end
        tdone("persist");
        wr(8'h02, 8'h10);
        conv1(lo, 1'b0);
        host.level_clear(5'h00);
        wr(8'h02, 8'h20);
        conv1(lo, 1'b0);
        host.alert_clear(got, 0);
        chk(got, 1'b1);
        chk(int_line, 1'b1);
        conv1(hi, 1'b0);
        host.alert_clear(got, 25);
        chk(got, 1'b1);
        chk(int_line, 1'b1);
        tdone("every");
        results();
    end
endmodule
bind lti_top lti_asserts chk_i (.core_clk(core_clk), .rst(rst), .bus(bus), .conv(conv),
    .sf_cmd(sf_cmd), .alert_resp_req(alert_resp_req), .alert_resp_ack(alert_resp_ack),
    .scl_pin(scl_pin), .int_n_oe(int_n_oe));
`default_nettype wire
